// *** logic/lpst_map.svh ***
/*
  register offsets, field positions, reset values and timing figures of the
  panel sync timing generator.
  assumes inclusion by bare name from the package and the design module.
*/
`ifndef LPST_MAP_SVH
`define LPST_MAP_SVH

`define LPST_OFF_CTRL 32'h0000_0000
`define LPST_OFF_SIZE 32'h0000_0004
`define LPST_OFF_HPAR 32'h0000_0008
`define LPST_OFF_VPAR 32'h0000_000C
`define LPST_OFF_CKDV 32'h0000_0010
`define LPST_OFF_STAT 32'h0000_0014

`define LPST_CTRL_EN_BIT 0
`define LPST_CTRL_LPOL_BIT 1
`define LPST_CTRL_FPOL_BIT 2
`define LPST_CKDV_INV_BIT 0
`define LPST_CKDV_DLY_LSB 4
`define LPST_CKDV_DLY_MSB 5
`define LPST_CKDV_DIV_LSB 8
`define LPST_CKDV_DIV_MSB 15

`define LPST_CTRL_RST 32'h0000_0000
`define LPST_SIZE_RST 32'h0010_0010
`define LPST_HPAR_RST 32'h0004_0404
`define LPST_VPAR_RST 32'h0002_0202
`define LPST_CKDV_RST 32'h0000_0300

`define LPST_MIN_PCP_PS 7500
`define LPST_MIN_DIV 3

`endif

// *** logic/lpst_pkg.sv ***
/*
  types shared by the panel sync timing generator.
  assumes lpst_map.svh is on the include path.
*/
`default_nettype none
package lpst_pkg;
  `include "lpst_map.svh"

  typedef enum logic [1:0] {
    LPST_SYNC = 2'b00,
    LPST_BACK = 2'b01,
    LPST_ACT = 2'b11,
    LPST_FRONT = 2'b10
  } lpst_phase_t;

  typedef struct packed {
    logic clk;
    logic line;
    logic frame;
    logic de;
    logic [23:0] data;
  } lpst_panel_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] size;
    logic [31:0] hpar;
    logic [31:0] vpar;
    logic [31:0] ckdv;
    logic [31:0] rdat;
    logic ack;
    logic [7:0] div_cnt;
    logic pclk;
    logic [3:0] ph_hist;
    lpst_phase_t hph;
    lpst_phase_t vph;
    logic [11:0] hcnt;
    logic [11:0] vcnt;
    logic [11:0] xpos;
    logic [11:0] ypos;
    logic line_act;
    logic frame_act;
    logic de;
    logic [23:0] data;
    logic [15:0] frames;
  } lpst_state_t;
endpackage : lpst_pkg
`default_nettype wire

// *** logic/lpst_timing_gen.sv ***
/*
  panel line and frame timing generator with a classic wishbone slave.
  register map, byte offsets:
    0x00 control: bit 0 enable, bit 1 line sync active low,
         bit 2 frame sync active low
    0x04 active area size: [11:0] width in pixels, [27:16] height in lines
    0x08 line sync params: [7:0] pulse, [15:8] back porch, [23:16] front porch
    0x0c frame sync params: same fields, counted in whole lines
    0x10 clock divider control: bit 0 invert panel clock, [5:4] phase delay
         in clk cycles, [15:8] divide ratio, ratios below three act as three
    0x14 status, read only: [1:0] line phase, [3:2] frame phase, bit 4 line
         sync active, bit 5 frame sync active, [31:16] frames completed
  unmapped offsets read zero, ignore writes and are still acknowledged.
  assumes a single 25 MHz clock; pixel data arrives synchronously on the
  same clock and is taken on each pixel clock rising edge while de is high.
  assumes software programs the sizes before it sets the enable bit.
*/
// Summary of operation
// R01 - outputs launch on pixel clock rising edge
// R02 - panel clock follows pixel clock polarity; the code inverts it when divider control bit 0 is set
// R03 - selectable sync polarity, active-high after reset
// R04 - data enable always active-high
// R05 - line: pulse, back porch, active, front
// R06 - frame intervals counted in whole lines
// R07 - size and sync counts programmable by software
// R08 - software keeps pixel clock at most third
// R09 - software keeps pixel period over 7.5ns
// R10 - panel clock edge and phase selectable
// R11 - data enable only in active pixels
`default_nettype none
`include "lpst_map.svh"
module lpst_timing_gen
  import lpst_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [23:0] pixel_in,
  output logic pixel_req,
  output logic [11:0] pixel_x,
  output logic [11:0] pixel_y,
  output lpst_panel_t panel_out
);

  lpst_state_t s_reg;
  lpst_state_t s_next;

  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : wb_merge

  // a zero count would wrap the last-count compare into a 4096-count phase, so treat it as a count of one
  function automatic logic [11:0] at_least_one(input logic [11:0] v);
    return (v == 12'h000) ? 12'h001 : v;
  endfunction : at_least_one

  function automatic logic [11:0] phase_len(input lpst_phase_t ph,
                                           input logic [11:0] pw,
                                           input logic [11:0] bp,
                                           input logic [11:0] act,
                                           input logic [11:0] fp);
    logic [11:0] r;
    r = pw;
    unique case (ph)
      LPST_SYNC: r = pw;
      LPST_BACK: r = bp;
      LPST_ACT: r = act;
      LPST_FRONT: r = fp;
    endcase
    return at_least_one(r);
  endfunction : phase_len

  // lines and frames walk the same four phases in the same order
  function automatic lpst_phase_t next_phase(input lpst_phase_t ph);
    lpst_phase_t r;
    r = LPST_SYNC;
    unique case (ph)
      LPST_SYNC: r = LPST_BACK;
      LPST_BACK: r = LPST_ACT;
      LPST_ACT: r = LPST_FRONT;
      LPST_FRONT: r = LPST_SYNC;
    endcase
    return r;
  endfunction : next_phase

  // an 8-bit count field of a sync parameter word, widened to counter size
  function automatic logic [11:0] count_field(input logic [31:0] par,
                                             input logic [1:0] idx);
    return {4'h0, par[idx*8 +: 8]};
  endfunction : count_field

  logic bus_req;
  logic [7:0] div_max;
  logic [1:0] dly_sel;
  logic pclk_rise;
  logic [11:0] hlen;
  logic [11:0] vlen;
  logic line_end;
  logic hdly;
  logic h_last;
  logic v_last;
  logic act_pixel;

  assign bus_req = wb_cyc_i && wb_stb_i && !s_reg.ack;
  // never divide below three, so the pixel rate stays within a third of clk
  assign div_max = (s_reg.ckdv[`LPST_CKDV_DIV_MSB:`LPST_CKDV_DIV_LSB] < 8'(`LPST_MIN_DIV))
    ? 8'(`LPST_MIN_DIV - 1)
    : s_reg.ckdv[`LPST_CKDV_DIV_MSB:`LPST_CKDV_DIV_LSB] - 8'h01; // R08
  assign dly_sel = s_reg.ckdv[`LPST_CKDV_DLY_MSB:`LPST_CKDV_DLY_LSB];
  // >= rather than ==: a divide lowered mid-period ends the period at once
  // instead of running the counter round through all 256 values
  assign pclk_rise = (s_reg.div_cnt >= div_max);
  // horizontal counts: pulse byte 0, back porch byte 1, front porch byte 2
  assign hlen = phase_len(s_reg.hph,
    count_field(s_reg.hpar, 2'h0),
    count_field(s_reg.hpar, 2'h1),
    s_reg.size[11:0],
    count_field(s_reg.hpar, 2'h2)); // R05 R07
  assign vlen = phase_len(s_reg.vph,
    count_field(s_reg.vpar, 2'h0),
    count_field(s_reg.vpar, 2'h1),
    s_reg.size[27:16],
    count_field(s_reg.vpar, 2'h2)); // R06 R07
  // same reasoning for the phase counters when software shrinks a count
  assign h_last = (s_reg.hcnt >= hlen - 12'h001);
  assign v_last = (s_reg.vcnt >= vlen - 12'h001);
  assign line_end = (s_reg.hph == LPST_FRONT) && h_last;
  assign act_pixel = (s_reg.hph == LPST_ACT) && (s_reg.vph == LPST_ACT);
  // history bit k is the pixel clock k + 1 clocks ago, so delay d reads bit d - 1
  assign hdly = s_reg.ph_hist[dly_sel - 2'h1];

  // one next-state process for the bus slave, the pixel clock divider, the
  // line and frame counters and the output registers; the sync, enable and data
  // outputs are registered here and leave on the same clock edge, the panel clock after its phase delay
  always_comb
  begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    if (bus_req)
    begin
      s_next.ack = 1'b1;
      if (wb_we_i)
      begin
        unique case (wb_adr_i)
          `LPST_OFF_CTRL: s_next.ctrl = wb_merge(s_reg.ctrl, wb_dat_i, wb_sel_i);
          `LPST_OFF_SIZE: s_next.size = wb_merge(s_reg.size, wb_dat_i, wb_sel_i);
          `LPST_OFF_HPAR: s_next.hpar = wb_merge(s_reg.hpar, wb_dat_i, wb_sel_i);
          `LPST_OFF_VPAR: s_next.vpar = wb_merge(s_reg.vpar, wb_dat_i, wb_sel_i);
          `LPST_OFF_CKDV: s_next.ckdv = wb_merge(s_reg.ckdv, wb_dat_i, wb_sel_i);
          default: s_next.rdat = 32'h0000_0000;
        endcase
        s_next.rdat = 32'h0000_0000;
      end
      else
      begin
        unique case (wb_adr_i)
          `LPST_OFF_CTRL: s_next.rdat = s_reg.ctrl;
          `LPST_OFF_SIZE: s_next.rdat = s_reg.size;
          `LPST_OFF_HPAR: s_next.rdat = s_reg.hpar;
          `LPST_OFF_VPAR: s_next.rdat = s_reg.vpar;
          `LPST_OFF_CKDV: s_next.rdat = s_reg.ckdv;
          `LPST_OFF_STAT: s_next.rdat = {s_reg.frames, 10'h000, s_reg.frame_act,
            s_reg.line_act, s_reg.vph, s_reg.hph};
          default: s_next.rdat = 32'h0000_0000;
        endcase
      end
    end
    s_next.div_cnt = pclk_rise ? 8'h00 : s_reg.div_cnt + 8'h01;
    // pixel clock high in the first half of the divide period; at the
    // minimum divide of three it is high for two clocks out of three
    s_next.pclk = (s_next.div_cnt <= (div_max >> 1));
    // disabled: park at the start of a sync pulse so enabling starts a clean frame
    if (!s_reg.ctrl[`LPST_CTRL_EN_BIT])
    begin
      s_next.hph = LPST_SYNC;
      s_next.vph = LPST_SYNC;
      s_next.hcnt = 12'h000;
      s_next.vcnt = 12'h000;
      s_next.xpos = 12'h000;
      s_next.ypos = 12'h000;
      s_next.line_act = 1'b0;
      s_next.frame_act = 1'b0;
      s_next.de = 1'b0;
    end
    else if (pclk_rise)
    begin
      // R01: line, frame, enable and data outputs launch here, on the pixel clock rise
      s_next.de = act_pixel; // R11 R04
      s_next.line_act = (s_reg.hph == LPST_SYNC);
      s_next.frame_act = (s_reg.vph == LPST_SYNC);
      if (s_next.de)
      begin
        s_next.data = pixel_in;
      end
      if (s_reg.hph == LPST_ACT)
      begin
        s_next.xpos = s_reg.xpos + 12'h001;
      end
      if (h_last)
      begin
        s_next.hcnt = 12'h000;
        s_next.hph = next_phase(s_reg.hph); // R05
        if (line_end)
        begin
          s_next.xpos = 12'h000;
          if (s_reg.vph == LPST_ACT)
          begin
            s_next.ypos = s_reg.ypos + 12'h001;
          end
          if (v_last)
          begin
            s_next.vcnt = 12'h000;
            s_next.vph = next_phase(s_reg.vph); // R06
            if (s_reg.vph == LPST_FRONT)
            begin
              s_next.ypos = 12'h000;
              s_next.frames = s_reg.frames + 16'h0001;
            end
          end
          else
          begin
            s_next.vcnt = s_reg.vcnt + 12'h001;
          end
        end
      end
      else
      begin
        s_next.hcnt = s_reg.hcnt + 12'h001;
      end
    end
    // shift register of the pixel clock gives selectable phase delay
    s_next.ph_hist = {s_reg.ph_hist[2:0], s_reg.pclk}; // R10
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_reg <= '0;
      s_reg.ctrl <= `LPST_CTRL_RST; // R03
      s_reg.size <= `LPST_SIZE_RST;
      s_reg.hpar <= `LPST_HPAR_RST;
      s_reg.vpar <= `LPST_VPAR_RST;
      s_reg.ckdv <= `LPST_CKDV_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_o = s_reg.rdat;
  assign wb_ack_o = s_reg.ack;
  assign pixel_req = s_reg.ctrl[`LPST_CTRL_EN_BIT] && pclk_rise && act_pixel; // R11
  assign pixel_x = s_reg.xpos;
  assign pixel_y = s_reg.ypos;
  // delay 0 forwards the pixel clock as is; inversion selects the falling edge
  assign panel_out.clk = (dly_sel == 2'b00 ? s_reg.pclk : hdly)
    ^ s_reg.ckdv[`LPST_CKDV_INV_BIT]; // R02 R10
  assign panel_out.line = s_reg.line_act ^ s_reg.ctrl[`LPST_CTRL_LPOL_BIT]; // R03
  assign panel_out.frame = s_reg.frame_act ^ s_reg.ctrl[`LPST_CTRL_FPOL_BIT]; // R03
  assign panel_out.de = s_reg.de; // R04
  assign panel_out.data = s_reg.data;

endmodule : lpst_timing_gen
`default_nettype wire

// *** verif/lpst_panel_model.sv ***
/* panel model: counts enabled pixels per line and lines per frame.
   assumes the forwarded clock runs one full cycle per pixel. */
`default_nettype none
module lpst_panel_model
  import lpst_pkg::*;
(
  input wire lpst_panel_t panel_in,
  output logic [11:0] line_px,
  output logic [11:0] frame_ln
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] px_cnt = 12'h000;
  logic [11:0] ln_cnt = 12'h000;
  // with inversion or a phase delay this edge can be the launch edge itself,
  // so the sample is taken 1 ns later, once the launch has settled
  always @(negedge panel_in.clk)
  begin
    #1;
    if (panel_in.de)
      px_cnt <= px_cnt + 12'h001;
    else if (px_cnt != 12'h000)
    begin
      line_px <= px_cnt;
      ln_cnt <= ln_cnt + 12'h001;
      px_cnt <= 12'h000;
    end
  end
  always @(posedge panel_in.frame)
  begin
    frame_ln <= ln_cnt;
    ln_cnt <= 12'h000;
  end
endmodule : lpst_panel_model
`default_nettype wire

// *** verif/lpst_timing_gen_properties.sv ***
/* port checks of the timing generator.
   assumes it is bound onto lpst_timing_gen. */
`default_nettype none
module lpst_checker
  import lpst_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [23:0] pixel_in,
  input wire logic pixel_req,
  input wire lpst_panel_t panel_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence quiet_two;
    !pixel_req ##1 !pixel_req;
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack unasked");
  req_space_a: assert property (pixel_req |=> quiet_two) else $error("requests close");
  de_follow_a: assert property (pixel_req |=> panel_out.de) else $error("no de");
  data_take_a: assert property (pixel_req |=> panel_out.data == $past(pixel_in))
    else $error("pixel lost");
  de_cause_a: assert property ($rose(panel_out.de) |-> $past(pixel_req))
    else $error("de unasked");
  de_hold_a: assert property ($changed(panel_out.de) |=> $stable(panel_out.de)[*2])
    else $error("de short");
  de_drop_a: assert property ($fell(panel_out.de) |-> !$past(pixel_req))
    else $error("de dropped");
endmodule : lpst_checker
bind lpst_timing_gen lpst_checker u_chk (.clk(clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .pixel_in(pixel_in), .pixel_req(pixel_req), .panel_out(panel_out));
`default_nettype wire

// *** verif/test_lcd_panel_sync_timing_generator.sv ***
/* bench: registers over wishbone, line and frame shape, sync polarity.
   assumes the checker and panel model are compiled first. */
`default_nettype none
`include "lpst_map.svh"
module test_lcd_panel_sync_timing_generator
  import lpst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0000_0000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic [23:0] pix = 24'h00_0000;
  logic [31:0] rdat, ck;
  logic ack, preq;
  lpst_panel_t pout;
  logic [11:0] line_px, frame_ln;
  logic [11:0] px, py;
  logic [31:0] exp_v;
  logic [23:0] pix_note = 24'h00_0000;
  logic [23:0] pix_q[$];
  logic pix_due = 1'b0;
  logic [11:0] exp_x = 12'h000;
  logic [11:0] exp_y = 12'h000;
  // active area that the scenario programs; expectations count from these
  localparam logic [11:0] act_w = 12'h005;
  localparam logic [11:0] act_h = 12'h003;
  logic [31:0] exp_q[$];
  logic [31:0] rst_tab [5] = '{`LPST_CTRL_RST, `LPST_SIZE_RST, `LPST_HPAR_RST,
    `LPST_VPAR_RST, `LPST_CKDV_RST};
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
`define CHK(n, e, s) checks_done++; if ((s) !== (e)) begin \
  $display("BAD %s exp %h got %h", n, e, s); bad_count++; end
  lpst_timing_gen u_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pixel_in(pix), .pixel_req(preq), .pixel_x(px), .pixel_y(py),
    .panel_out(pout));
  lpst_panel_model u_panel (.panel_in(pout), .line_px(line_px), .frame_ln(frame_ln));
  initial forever #20 clk = ~clk;
  task automatic end_of_test();
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge clk)
  begin
    pix <= 24'($urandom);
    cycles++;
    if (cycles > 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  always @(posedge clk)
  begin
    if (ack && !we)
    begin
      exp_v = exp_q.pop_front();
      `CHK("read", exp_v, rdat)
    end
  end
  // each requested pixel shows on the panel data one clock later, at the
  // position that the active area counts out in raster order
  always @(posedge clk)
  begin
    if (pix_due)
    begin
      pix_note = pix_q.pop_front();
      `CHK("pixel data", pix_note, pout.data)
    end
    pix_due = preq;
    if (preq)
    begin
      pix_q.push_back(pix);
      `CHK("pixel x", exp_x, px)
      `CHK("pixel y", exp_y, py)
      exp_x = (exp_x == act_w - 12'h001) ? 12'h000 : exp_x + 12'h001;
      if (exp_x == 12'h000)
        exp_y = (exp_y == act_h - 12'h001) ? 12'h000 : exp_y + 12'h001;
    end
  end
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [31:0] e);
    if (!w)
      exp_q.push_back(e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  initial
  begin
    void'($urandom(72672));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
      bus(1'b0, 32'(i * 4), 32'h0000_0000, 4'hF, rst_tab[i]);
    bus(1'b1, 32'h0000_0018, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000);
    bus(1'b0, 32'h0000_0018, 32'h0000_0000, 4'hF, 32'h0000_0000);
    bus(1'b1, `LPST_OFF_SIZE, {4'h0, act_h, 4'h0, act_w}, 4'hF, 32'h0000_0000);
    bus(1'b1, `LPST_OFF_HPAR, 32'hFF01_0201, 4'h7, 32'h0000_0000);
    bus(1'b1, `LPST_OFF_VPAR, 32'h0001_0101, 4'hF, 32'h0000_0000);
    bus(1'b0, `LPST_OFF_HPAR, 32'h0000_0000, 4'hF, 32'h0001_0201);
    // divide held at 3 so the pixel clock stays within a third of clk
    ck = 32'h0000_0300 | (32'($urandom) & 32'h0000_0031);
    bus(1'b1, `LPST_OFF_CKDV, ck, 4'hF, 32'h0000_0000);
    bus(1'b0, `LPST_OFF_CKDV, 32'h0000_0000, 4'hF, ck);
    for (int p = 0; p < 2; p++)
    begin
      bus(1'b1, `LPST_OFF_CTRL, 32'(1 + 6 * p), 4'hF, 32'h0000_0000);
      repeat (4) @(posedge pout.frame);
      @(posedge pout.de);
      @(negedge clk);
      `CHK("line sync", 1'(p), pout.line)
      `CHK("frame sync", 1'(p), pout.frame)
      `CHK("line pixels", act_w, line_px)
      `CHK("frame lines", act_h, frame_ln)
    end
    end_of_test();
  end
endmodule : test_lcd_panel_sync_timing_generator
`default_nettype wire
